// ### verilog/l2tp_encap_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types for the tunnel header encapsulators
// ----------------------------------------------------------------------------
package l2tp_encap_pkg;

   // Bus and table shapes
   localparam int ADDR_W = 8;    // Avalon byte address width
   localparam int DATA_W = 32;   // Avalon data width
   localparam int FLOWS = 8;     // Upstream flow identifiers (3-bit)
   localparam int FLOW_W = 3;
   localparam int DSCP_W = 6;
   localparam int PEERS = 4;     // Headend endpoint addresses held by the node

   // Protocol figures
   localparam logic [15:0] L2TP_WELL_KNOWN_PORT = 16'h06a5;  // 1701
   localparam logic [5:0] DSCP_BEST_EFFORT = 6'h00;
   localparam logic [15:0] PORT_RESET = 16'hc000;            // Ephemeral default
   localparam logic [31:0] ADDR_RESET = 32'h00000000;
   localparam int PCP_LSB = 3;   // User priority taken from top DSCP bits

   // Remote node register offsets
   localparam logic [7:0] REG_N_CTRL = 8'h00;
   localparam logic [7:0] REG_N_CMD = 8'h04;
   localparam logic [7:0] REG_N_PORT = 8'h08;
   localparam logic [7:0] REG_N_LOCAL = 8'h0c;
   localparam logic [7:0] REG_N_PEER0 = 8'h10;  // Four words, 0x10..0x1c
   localparam logic [7:0] REG_N_REJECT = 8'h20;
   localparam logic [7:0] REG_N_CDSCP = 8'h24;

   // Headend register offsets
   localparam logic [7:0] REG_H_CTRL = 8'h00;
   localparam logic [7:0] REG_H_CMD = 8'h04;
   localparam logic [7:0] REG_H_PORT = 8'h08;
   localparam logic [7:0] REG_H_CDSCP = 8'h0c;
   localparam logic [7:0] REG_H_LOCAL = 8'h10;
   localparam logic [7:0] REG_H_NODEPORT = 8'h14;
   localparam logic [7:0] REG_H_LASTUP = 8'h18;
   localparam logic [7:0] REG_H_FLOW0 = 8'h20;  // Eight words, 0x20..0x3c

   // Field positions
   localparam int CTRL_UDP_BIT = 0;
   localparam int CTRL_IPV6_BIT = 1;
   localparam int CTRL_VLAN_BIT = 2;
   localparam int CMD_KIND_LSB = 0;
   localparam int CMD_FLOW_LSB = 4;
   localparam int CMD_DEF_BIT = 8;

   // Message kinds carried in a header descriptor
   typedef enum logic [2:0] {
      MSG_SCCRQ = 3'h0,
      MSG_SCCRP = 3'h1,
      MSG_CTRL = 3'h2,
      MSG_DATA = 3'h3,
      MSG_PROBE = 3'h4,
      MSG_SBFD = 3'h5
   } msg_t;

   // Outer header descriptor, one per packet
   typedef struct packed {
      msg_t kind;
      logic ipv6;                   // IPv6 instead of IPv4
      logic df;                     // Don't-fragment flag
      logic [5:0] dscp;
      logic udp;                    // UDP header present
      logic [15:0] src_port;
      logic [15:0] dst_port;
      logic [2:0] flow_id;
      logic dst_mac_group;          // Group bit of destination MAC
      logic vlan;                   // 802.1Q tag present
      logic [2:0] pcp;
      logic [31:0] endpoint_addr;   // Sender tunnel_endpoint address
      logic attr_dscp_valid;        // Control-connection DSCP attribute
      logic [5:0] attr_dscp;
      logic flowdef_valid;          // Upstream flow definition
      logic [2:0] flowdef_id;
      logic [5:0] flowdef_phb;
   } hdr_t;

endpackage

// ### verilog/l2tp_link_if.sv
// ----------------------------------------------------------------------------
// Link between headend_core and remote node
// ----------------------------------------------------------------------------
interface l2tp_link_if;
   import l2tp_encap_pkg::*;

   logic down_valid;    // One-cycle packet strobe, headend to node
   hdr_t down_hdr;
   logic up_valid;      // One-cycle packet strobe, node to headend
   hdr_t up_hdr;
   logic udp_capable;   // Capability level over configuration_channel

   modport node (input down_valid, input down_hdr, output up_valid, output up_hdr,
      output udp_capable);
   modport headend (output down_valid, output down_hdr, input up_valid, input up_hdr,
      input udp_capable);
endinterface // l2tp_link_if

// ### verilog/flow_phb_table.sv
// ----------------------------------------------------------------------------
// Per-flow PHB table of the remote node
// ----------------------------------------------------------------------------
module flow_phb_table import l2tp_encap_pkg::*; #(
   parameter int N = FLOWS
) (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic clear_in,                 // New control session
   input wire logic wr_in,                    // Accepted flow definition
   input wire logic [FLOW_W-1:0] wr_flow_in,
   input wire logic [DSCP_W-1:0] wr_phb_in,
   output logic [N-1:0][DSCP_W-1:0] phb_out,
   output logic [N-1:0] defined_out
);

   typedef struct packed {
      logic [N-1:0][DSCP_W-1:0] phb;
      logic [N-1:0] defined;
   } table_t;

   table_t s, next_s;
   logic [N-1:0] hit;   // Entry addressed by the definition

   // Per-entry address match
   for (genvar i = 0; i < N; i++) begin : g_hit
      assign hit[i] = wr_in && (wr_flow_in == FLOW_W'(i));
   end

   // Definition overrides a clear in the same cycle
   always_comb begin
      next_s = s;
      if (clear_in) begin
         next_s.defined = '0;
      end
      for (int i = 0; i < N; i++) begin
         if (hit[i]) begin
            next_s.phb[i] = wr_phb_in;
            next_s.defined[i] = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign phb_out = s.phb;
   assign defined_out = s.defined;
endmodule // flow_phb_table

// ### verilog/remote_node_encap.sv
// Behaviour
// - Every transmitted packet sets don't-fragment
// - Headend DSCP is configurable, 6 bits
// - Accept four headend endpoint addresses
// - One endpoint address per control session
// - Headend sends nonzero control DSCP attribute
// - Upstream control DSCP from attribute, else zero
// - Headend probe DSCP follows probed flow policy
// - Headend defines upstream flow per probed flow
// - Probe response uses matching flow PHB
// - S-BFD rides flow zero both ways
// - S-BFD response uses flow zero PHB
// - Headend flow definition PHB equals policy DSCP
// - Upstream data uses its flow's PHB
// - Report UDP capability over configuration_channel
// - Headend adds UDP when configured and capable
// - Node adds UDP after UDP connection request
// - Connection request goes to port 1701
// - Reply goes to headend control port
// - Headend later control uses node port
// - Node later control uses both ports
// - Destination MAC is an individual address
// - User priority derived from DSCP, tag optional
// - Probe response on matching flow, else zero
module remote_node_encap import l2tp_encap_pkg::*; #(
   parameter int PEER_COUNT = PEERS
) (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   output logic [DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   l2tp_link_if.node link
);

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic ack;                              // Bus answer cycle
      logic [DATA_W-1:0] rdata;
      logic udp_capable;
      logic ipv6;
      logic vlan_en;
      logic [15:0] node_port;                 // Our control port
      logic [15:0] core_port;                 // Learned headend port
      logic [31:0] local_addr;
      logic [31:0] ep_addr;                   // Headend address of session
      logic [PEER_COUNT-1:0][31:0] peer_addr;
      logic [15:0] reject_cnt;
      logic [5:0] ctrl_dscp;
      logic udp_active;
      logic session_up;
      logic cmd_pend;
      msg_t cmd_kind;
      logic [2:0] cmd_flow;
      logic sccrp_pend;
      logic probe_pend;
      logic [2:0] probe_flow;
      logic sbfd_pend;
      logic up_valid;
      hdr_t up_hdr;
   } node_state_t;

   node_state_t s, next_s;
   hdr_t dh;                                  // Incoming descriptor
   logic [PEER_COUNT-1:0] peer_hit;           // Sender address matches
   logic accept;                              // Downstream packet taken
   logic [FLOWS-1:0][DSCP_W-1:0] phb;
   logic [FLOWS-1:0] defined;
   logic new_session;

   assign dh = link.down_hdr;

   // ----------------------------------------------------------------------------
   // Address filter
   // ----------------------------------------------------------------------------
   // Any of the held headend addresses passes the sender match
   for (genvar i = 0; i < PEER_COUNT; i++) begin : g_peer
      assign peer_hit[i] = (dh.endpoint_addr == s.peer_addr[i]);
   end

   // Group MACs dropped; after setup only the session's address passes, except requests from any held address
   assign accept = link.down_valid && (|peer_hit) && !dh.dst_mac_group
      && (!s.session_up || dh.kind == MSG_SCCRQ || dh.endpoint_addr == s.ep_addr);
   assign new_session = accept && dh.kind == MSG_SCCRQ && !s.session_up;

   // Flow definitions fill the PHB table
   flow_phb_table #(.N(FLOWS)) u_flows (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .clear_in(new_session),
      .wr_in(accept && dh.flowdef_valid),
      .wr_flow_in(dh.flowdef_id),
      .wr_phb_in(dh.flowdef_phb),
      .phb_out(phb),
      .defined_out(defined)
   );

   // ----------------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------------
   always_comb begin
      logic acc;
      logic wr;
      msg_t k;
      logic [2:0] f;
      logic [DATA_W-1:0] rd;
      acc = 1'b0;
      wr = 1'b0;
      k = MSG_CTRL;
      f = 3'h0;
      rd = '0;
      next_s = s;
      next_s.ack = 1'b0;
      next_s.up_valid = 1'b0;

      // Read mux; unmapped reads give zero
      unique case (avs_address_in)
         REG_N_CTRL: rd = {29'h0, s.vlan_en, s.ipv6, s.udp_capable};
         REG_N_CMD: rd = {29'h0, s.session_up, s.udp_active, s.cmd_pend};
         REG_N_PORT: rd = {16'h0, s.node_port};
         REG_N_LOCAL: rd = s.local_addr;
         REG_N_REJECT: rd = {16'h0, s.reject_cnt};
         REG_N_CDSCP: rd = {26'h0, s.ctrl_dscp};
         default: begin
            for (int i = 0; i < PEER_COUNT; i++) begin
               if (avs_address_in == REG_N_PEER0 + ADDR_W'(4 * i)) begin
                  rd = s.peer_addr[i];
               end
            end
         end
      endcase

      // Answer one cycle after the request; a command write waits while one is queued
      acc = (avs_read_in || avs_write_in) && !s.ack
         && !(avs_write_in && avs_address_in == REG_N_CMD && s.cmd_pend);
      if (acc) begin
         next_s.ack = 1'b1;
         next_s.rdata = rd;
      end
      wr = avs_write_in && s.ack;

      // Transmit first so that a same-cycle arrival re-raises its flag
      if (s.sccrp_pend) begin
         k = MSG_SCCRP;
         next_s.sccrp_pend = 1'b0;
      end else if (s.probe_pend) begin
         k = MSG_PROBE;
         f = defined[s.probe_flow] ? s.probe_flow : 3'h0;
         next_s.probe_pend = 1'b0;
      end else if (s.sbfd_pend) begin
         k = MSG_SBFD;
         f = 3'h0;
         next_s.sbfd_pend = 1'b0;
      end else if (s.cmd_pend) begin
         k = (s.cmd_kind == MSG_DATA) ? MSG_DATA : MSG_CTRL;
         f = s.cmd_flow;
         next_s.cmd_pend = 1'b0;
      end
      if (s.sccrp_pend || s.probe_pend || s.sbfd_pend || s.cmd_pend) begin
         next_s.up_valid = 1'b1;
         next_s.up_hdr = '0;
         next_s.up_hdr.kind = k;
         next_s.up_hdr.flow_id = f;
         next_s.up_hdr.df = 1'b1;
         next_s.up_hdr.ipv6 = s.ipv6;
         next_s.up_hdr.dst_mac_group = 1'b0;
         next_s.up_hdr.vlan = s.vlan_en;
         next_s.up_hdr.endpoint_addr = s.local_addr;
         // Control uses the attribute DSCP, the rest the flow's PHB
         if (k == MSG_SCCRP || k == MSG_CTRL) begin
            next_s.up_hdr.dscp = s.ctrl_dscp;
         end else begin
            next_s.up_hdr.dscp = phb[f];
         end
         next_s.up_hdr.pcp = next_s.up_hdr.dscp[DSCP_W-1:PCP_LSB];
         next_s.up_hdr.udp = s.udp_active;
         if (s.udp_active) begin
            next_s.up_hdr.src_port = s.node_port;
            next_s.up_hdr.dst_port = s.core_port;
         end
      end

      // Register writes take effect in the answer cycle
      if (wr) begin
         unique case (avs_address_in)
            REG_N_CTRL: begin
               next_s.udp_capable = avs_writedata_in[CTRL_UDP_BIT];
               next_s.ipv6 = avs_writedata_in[CTRL_IPV6_BIT];
               next_s.vlan_en = avs_writedata_in[CTRL_VLAN_BIT];
            end
            REG_N_CMD: begin
               next_s.cmd_pend = 1'b1;
               next_s.cmd_kind = msg_t'(avs_writedata_in[CMD_KIND_LSB+:3]);
               next_s.cmd_flow = avs_writedata_in[CMD_FLOW_LSB+:FLOW_W];
            end
            REG_N_PORT: next_s.node_port = avs_writedata_in[15:0];
            REG_N_LOCAL: next_s.local_addr = avs_writedata_in;
            default: begin
               for (int i = 0; i < PEER_COUNT; i++) begin
                  if (avs_address_in == REG_N_PEER0 + ADDR_W'(4 * i)) begin
                     next_s.peer_addr[i] = avs_writedata_in;
                  end
               end
            end
         endcase
      end

      // Downstream packets: refused ones are only counted
      if (link.down_valid && !accept) begin
         next_s.reject_cnt = s.reject_cnt + 16'h0001;
      end
      if (accept) begin
         if (dh.attr_dscp_valid) begin
            next_s.ctrl_dscp = dh.attr_dscp;
         end
         unique case (dh.kind)
            MSG_SCCRQ: begin
               next_s.sccrp_pend = 1'b1;
               // Only the first request fixes address, port and UDP use
               if (!s.session_up) begin
                  next_s.session_up = 1'b1;
                  next_s.ep_addr = dh.endpoint_addr;
                  next_s.core_port = dh.src_port;
                  next_s.udp_active = s.udp_capable && dh.udp;
               end
            end
            MSG_PROBE: begin
               next_s.probe_pend = 1'b1;
               next_s.probe_flow = dh.flow_id;
            end
            MSG_SBFD: next_s.sbfd_pend = 1'b1;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------------
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s <= '0;
         s.node_port <= PORT_RESET;
         s.local_addr <= ADDR_RESET;
         s.ctrl_dscp <= DSCP_BEST_EFFORT;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata_out = s.rdata;
   assign avs_waitrequest_out = !s.ack;
   assign link.up_valid = s.up_valid;
   assign link.up_hdr = s.up_hdr;
   assign link.udp_capable = s.udp_capable;
endmodule // remote_node_encap

// ### verilog/headend_core_encap.sv
// ----------------------------------------------------------------------------
// headend_core end of the tunnel header link
// ----------------------------------------------------------------------------
module headend_core_encap import l2tp_encap_pkg::*; (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   output logic [DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   l2tp_link_if.headend link
);

   typedef struct packed {
      logic ack;
      logic [DATA_W-1:0] rdata;
      logic udp_cfg;
      logic ipv6;
      logic vlan_en;
      logic [15:0] core_port;                 // Our control port
      logic [5:0] ctrl_dscp;                  // Control policy DSCP
      logic [31:0] local_addr;
      logic [FLOWS-1:0][5:0] flow_dscp;       // Per-flow policy DSCP
      logic [15:0] node_port;                 // Learned from reply
      logic node_port_known;
      logic [11:0] last_up;                   // Kind, flow, DSCP seen
      logic down_valid;
      hdr_t down_hdr;
   } head_state_t;

   head_state_t s, next_s;

   // Build a descriptor in the answer cycle of a command write
   always_comb begin
      logic [DATA_W-1:0] rd;
      msg_t k;
      logic [2:0] f;
      logic udp;
      rd = '0;
      k = msg_t'(avs_writedata_in[CMD_KIND_LSB+:3]);
      f = avs_writedata_in[CMD_FLOW_LSB+:FLOW_W];
      udp = s.udp_cfg && link.udp_capable;
      next_s = s;
      next_s.ack = 1'b0;
      next_s.down_valid = 1'b0;

      // Read mux; unmapped reads give zero
      unique case (avs_address_in)
         REG_H_CTRL: rd = {29'h0, s.vlan_en, s.ipv6, s.udp_cfg};
         REG_H_CMD: rd = {29'h0, link.udp_capable, s.node_port_known, udp};
         REG_H_PORT: rd = {16'h0, s.core_port};
         REG_H_CDSCP: rd = {26'h0, s.ctrl_dscp};
         REG_H_LOCAL: rd = s.local_addr;
         REG_H_NODEPORT: rd = {16'h0, s.node_port};
         REG_H_LASTUP: rd = {20'h0, s.last_up};
         default: begin
            for (int i = 0; i < FLOWS; i++) begin
               if (avs_address_in == REG_H_FLOW0 + ADDR_W'(4 * i)) begin
                  rd = {26'h0, s.flow_dscp[i]};
               end
            end
         end
      endcase
      if ((avs_read_in || avs_write_in) && !s.ack) begin
         next_s.ack = 1'b1;
         next_s.rdata = rd;
      end

      // Writes and commands
      if (avs_write_in && s.ack) begin
         unique case (avs_address_in)
            REG_H_CTRL: begin
               next_s.udp_cfg = avs_writedata_in[CTRL_UDP_BIT];
               next_s.ipv6 = avs_writedata_in[CTRL_IPV6_BIT];
               next_s.vlan_en = avs_writedata_in[CTRL_VLAN_BIT];
            end
            REG_H_PORT: next_s.core_port = avs_writedata_in[15:0];
            REG_H_CDSCP: next_s.ctrl_dscp = avs_writedata_in[5:0];
            REG_H_LOCAL: next_s.local_addr = avs_writedata_in;
            REG_H_CMD: begin
               if (k == MSG_SBFD) begin
                  f = 3'h0;
               end
               next_s.down_valid = 1'b1;
               next_s.down_hdr = '0;
               next_s.down_hdr.kind = k;
               next_s.down_hdr.flow_id = f;
               next_s.down_hdr.df = 1'b1;
               next_s.down_hdr.ipv6 = s.ipv6;
               next_s.down_hdr.vlan = s.vlan_en;
               next_s.down_hdr.endpoint_addr = s.local_addr;
               next_s.down_hdr.udp = udp;
               if (k == MSG_SCCRQ || k == MSG_CTRL) begin
                  next_s.down_hdr.dscp = s.ctrl_dscp;
               end else begin
                  next_s.down_hdr.dscp = s.flow_dscp[f];
               end
               next_s.down_hdr.pcp = next_s.down_hdr.dscp[DSCP_W-1:PCP_LSB];
               if (k == MSG_SCCRQ) begin
                  next_s.down_hdr.attr_dscp_valid = s.ctrl_dscp != DSCP_BEST_EFFORT;
                  next_s.down_hdr.attr_dscp = s.ctrl_dscp;
               end
               if (udp) begin
                  next_s.down_hdr.src_port = s.core_port;
                  next_s.down_hdr.dst_port = (k == MSG_SCCRQ) ? L2TP_WELL_KNOWN_PORT
                     : s.node_port;
               end
               // Flow definition carries the policy DSCP as its PHB
               if (avs_writedata_in[CMD_DEF_BIT]) begin
                  next_s.down_hdr.flowdef_valid = 1'b1;
                  next_s.down_hdr.flowdef_id = f;
                  next_s.down_hdr.flowdef_phb = s.flow_dscp[f];
               end
            end
            default: begin
               for (int i = 0; i < FLOWS; i++) begin
                  if (avs_address_in == REG_H_FLOW0 + ADDR_W'(4 * i)) begin
                     next_s.flow_dscp[i] = avs_writedata_in[5:0];
                  end
               end
            end
         endcase
      end

      // Upstream: record what came in, learn the node control port
      if (link.up_valid) begin
         // Twelve bits exactly: kind, flow, then the two DSCP halves swapped
         next_s.last_up = {link.up_hdr.kind, link.up_hdr.flow_id,
            link.up_hdr.dscp[2:0], link.up_hdr.dscp[5:3]};
         if (link.up_hdr.kind == MSG_SCCRP && link.up_hdr.udp) begin
            next_s.node_port = link.up_hdr.src_port;
            next_s.node_port_known = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s <= '0;
         s.core_port <= PORT_RESET;
         s.ctrl_dscp <= DSCP_BEST_EFFORT;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata_out = s.rdata;
   assign avs_waitrequest_out = !s.ack;
   assign link.down_valid = s.down_valid;
   assign link.down_hdr = s.down_hdr;
endmodule // headend_core_encap

// ### tb/l2tp_link_asserts.sv
// ----------------------------------------
// Link watcher between the two encapsulators
// ----------------------------------------
module l2tp_link_asserts import l2tp_encap_pkg::*; (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic down_valid,
   input wire hdr_t down_hdr,
   input wire logic up_valid,
   input wire hdr_t up_hdr,
   input wire logic udp_capable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   // Ports of the handshake, kept to judge later control packets
   logic [15:0] core_seen;
   logic [15:0] node_seen;
   // Capture request source and reply source ports
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         core_seen <= 16'h0000;
         node_seen <= 16'h0000;
      end else begin
         if (down_valid && down_hdr.kind == MSG_SCCRQ) begin
            core_seen <= down_hdr.src_port;
         end
         if (up_valid && up_hdr.kind == MSG_SCCRP) begin
            node_seen <= up_hdr.src_port;
         end
      end
   end
   a_down_no_frag: assert property (down_valid |-> down_hdr.df)
      else $error("down df clear");
   a_up_no_frag: assert property (up_valid |-> up_hdr.df)
      else $error("up df clear");
   a_down_unicast: assert property (down_valid |-> !down_hdr.dst_mac_group)
      else $error("down group mac");
   a_up_unicast: assert property (up_valid |-> !up_hdr.dst_mac_group)
      else $error("up group mac");
   a_request_port: assert property (down_valid && down_hdr.kind == MSG_SCCRQ
      && down_hdr.udp |-> down_hdr.dst_port == L2TP_WELL_KNOWN_PORT)
      else $error("request port wrong");
   // Reply leaves two cycles after the request, aimed at the port it came from
   a_reply_port: assert property (down_valid && down_hdr.kind == MSG_SCCRQ
      && down_hdr.udp |-> ##2 up_valid && up_hdr.kind == MSG_SCCRP
      && up_hdr.dst_port == $past(down_hdr.src_port, 2))
      else $error("reply port wrong");
   a_later_ports: assert property (down_valid && down_hdr.udp
      && down_hdr.kind == MSG_CTRL |-> down_hdr.dst_port == node_seen
      && down_hdr.src_port == core_seen) else $error("later control ports wrong");
   a_sbfd_flow: assert property (up_valid && up_hdr.kind == MSG_SBFD
      |-> up_hdr.flow_id == 3'h0) else $error("sbfd flow nonzero");
   a_prio_map: assert property (up_valid && up_hdr.vlan
      |-> up_hdr.pcp == up_hdr.dscp[5:3]) else $error("priority not from dscp");
   a_udp_gate: assert property (down_valid && down_hdr.udp |-> $past(udp_capable))
      else $error("udp without capability");
endmodule // l2tp_link_asserts

// ### tb/tb_l2tp_tunnel_header_encap.sv
module tb_l2tp_tunnel_header_encap import l2tp_encap_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Stimulus; index 0 is the node, 1 the headend
   // ----------------------------------------
   logic clock_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [ADDR_W-1:0] ad [2] = '{8'h00, 8'h00};
   logic rd [2] = '{1'b0, 1'b0};
   logic wr [2] = '{1'b0, 1'b0};
   logic [DATA_W-1:0] wd [2] = '{32'h0, 32'h0};
   logic [DATA_W-1:0] rq [2];
   logic wq [2];
   int failures = 0;
   int samples_checked = 0;
   logic [31:0] pc [3] = '{32'h034, 32'h054, 32'h105}; // Probe on 3, probe on 5, sbfd defining 0
   logic [31:0] pe [3] = '{32'h8d3, 32'h800, 32'ha21}; // Kind, flow, swapped DSCP back
   always #10 clock_in = ~clock_in;
   l2tp_link_if link ();
   remote_node_encap remote_node_encap_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .avs_address_in(ad[0]), .avs_read_in(rd[0]), .avs_write_in(wr[0]),
      .avs_writedata_in(wd[0]), .avs_readdata_out(rq[0]), .avs_waitrequest_out(wq[0]),
      .link(link.node));
   headend_core_encap headend_core_encap_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .avs_address_in(ad[1]), .avs_read_in(rd[1]), .avs_write_in(wr[1]),
      .avs_writedata_in(wd[1]), .avs_readdata_out(rq[1]), .avs_waitrequest_out(wq[1]),
      .link(link.headend));
   l2tp_link_asserts l2tp_link_asserts_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .down_valid(link.down_valid), .down_hdr(link.down_hdr), .up_valid(link.up_valid),
      .up_hdr(link.up_hdr), .udp_capable(link.udp_capable));
   // Held until waitrequest is sampled low at a rising edge; data taken at that edge
   task automatic acc(input int s, input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clock_in);
      rd[s] <= !w;
      wr[s] <= w;
      ad[s] <= a;
      wd[s] <= d;
      do begin
         @(posedge clock_in);
      end while (wq[s] !== 1'b0);
      q = rq[s];
      rd[s] <= 1'b0;
      wr[s] <= 1'b0;
   endtask
   task automatic put(input int s, input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(s, 1'b1, a, d, q);
   endtask
   task automatic check(input string what, input logic [31:0] m, input logic [31:0] e,
      input int s, input logic [7:0] a);
      logic [31:0] q;
      acc(s, 1'b0, a, 32'h0, q);
      samples_checked++;
      if ((q & m) !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, e, q & m);
      end
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock_in);
      failures++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge clock_in);
      arst_n_in <= 1'b1;
      check("node port reset", 32'hffff, 32'hc000, 0, REG_N_PORT);
      put(0, REG_N_CTRL, 32'h7);
      put(0, REG_N_PEER0, 32'h0a0000ff);
      put(0, REG_N_PEER0 + 8'h0c, 32'h0a000001);
      put(0, REG_N_PORT, 32'hc456);
      put(1, REG_H_LOCAL, 32'h0a000001);
      put(1, REG_H_CTRL, 32'h3);
      put(1, REG_H_PORT, 32'hc123);
      put(1, REG_H_CDSCP, 32'h2e);
      put(1, REG_H_CMD, 32'h0);
      // Request and reply take a few cycles to cross the link
      repeat (4) @(posedge clock_in);
      check("node port learned", 32'hffff, 32'hc456, 1, REG_H_NODEPORT);
      check("node ctrl dscp", 32'h3f, 32'h2e, 0, REG_N_CDSCP);
      check("node status", 32'h7, 32'h6, 0, REG_N_CMD);
      check("core status", 32'h7, 32'h7, 1, REG_H_CMD);
      put(1, REG_H_FLOW0, 32'h0c);
      put(1, REG_H_FLOW0 + 8'h0c, 32'h1a);
      put(1, REG_H_CMD, 32'h132);
      put(0, REG_N_CMD, 32'h33);
      repeat (4) @(posedge clock_in);
      check("up data flow", 32'hfff, 32'h6d3, 1, REG_H_LASTUP);
      for (int i = 0; i < 3; i++) begin
         put(1, REG_H_CMD, pc[i]);
         repeat (4) @(posedge clock_in);
         check("probe reply", 32'hfff, pe[i], 1, REG_H_LASTUP);
      end
      put(1, REG_H_LOCAL, 32'h0a0000ff);
      put(1, REG_H_CMD, 32'h2);
      check("reject count", 32'hffffffff, 32'h1, 0, REG_N_REJECT);
      check("unmapped", 32'hffffffff, 32'h0, 0, 8'hfc);
      report_and_stop();
   end
endmodule // tb_l2tp_tunnel_header_encap
